// ===== rtl/bls_defs.svh
// Shared constants of the backlight two-wire slave port and its host master.
`ifndef BLS_DEFS_SVH
`define BLS_DEFS_SVH
`define BLS_ADDR_WR 8'h58
`define BLS_ADDR_RD 8'h59
`define BLS_CLASS_NIBBLE 4'h5
`define BLS_ADDR_BIT3 3
`define BLS_DIR_BIT 0
`define BLS_REG_BRT 8'h00
`define BLS_REG_CTRL 8'h01
`define BLS_REG_STAT 8'h02
`define BLS_REG_ID 8'h03
`define BLS_REG_BRTDC 8'h07
`define BLS_REG_CFG 8'h08
`define BLS_REG_CHAN 8'h09
`define BLS_REG_PHASE 8'h0a
`define BLS_RST_BRT 8'hff
`define BLS_RST_CTRL 8'h00
`define BLS_RST_BRTDC 8'hff
`define BLS_RST_CFG 8'h1f
`define BLS_RST_CHAN 8'h3f
`define BLS_RST_PHASE 8'h00
`define BLS_CTRL_MASK 8'h07
`define BLS_CFG_MASK 8'h7f
`define BLS_CHAN_MASK 8'h3f
`define BLS_CTL_ON_BIT 0
`define BLS_CFG_FSW_BIT 2
`define BLS_STAT_ON_BIT 3
`define BLS_FSW_FIXED_KHZ 600
`define BLS_CLK_KHZ 40000
`define BLS_HOST_DIV 8'd50
`define BLS_UNUSED_LOW 11'd1024
`endif

// ===== rtl/bls_pkg.sv
// State types of both ends of the backlight two-wire port, one type for each end.
package bls_pkg;
   typedef enum logic [2:0] {
      BLS_ST_IDLE,
      BLS_ST_ADDR,
      BLS_ST_CMD,
      BLS_ST_DATA,
      BLS_ST_READ,
      BLS_ST_SKIP
   } bls_slv_state_e;
   typedef enum logic [3:0] {
      BLS_H_IDLE,
      BLS_H_START,
      BLS_H_BIT,
      BLS_H_ACK,
      BLS_H_RSTART,
      BLS_H_STOP,
      BLS_H_DONE
   } bls_host_state_e;
endpackage

// ===== rtl/bls_if.sv
// Two-wire bus between the backlight slave port and the host master.
`timescale 1ns/1ps
`default_nettype none
interface bls_if;
   logic clk_o;
   logic clk_oe_n;
   logic dat_h_o;
   logic dat_h_oe_n;
   logic dat_s_o;
   logic dat_s_oe_n;
   wire two_wire_clock_pin;
   wire two_wire_data_pin;
   // Open-drain resolution: a driven low wins, otherwise pulled up.
   assign two_wire_clock_pin = (!clk_oe_n && !clk_o) ? 1'b0 : 1'b1;
   assign two_wire_data_pin = ((!dat_h_oe_n && !dat_h_o) || (!dat_s_oe_n && !dat_s_o)) ? 1'b0
      : 1'b1;
   modport slave (
      input two_wire_clock_pin,
      input two_wire_data_pin,
      output dat_s_o,
      output dat_s_oe_n
   );
   modport host (
      input two_wire_clock_pin,
      input two_wire_data_pin,
      output clk_o,
      output clk_oe_n,
      output dat_h_o,
      output dat_h_oe_n
   );
endinterface
`default_nettype wire

// ===== rtl/bls_host.sv
// Host master end: runs three-byte writes and four-byte reads on the two-wire bus.
`timescale 1ns/1ps
`default_nettype none
`include "bls_defs.svh"
module bls_host import bls_pkg::*; #(
   parameter logic [7:0] HALF_DIV = `BLS_HOST_DIV
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // User command port.
   input wire logic req,
   input wire logic req_read,
   input wire logic [7:0] req_index,
   input wire logic [7:0] req_wdata,
   output logic busy,
   output logic done,
   output logic nack,
   output logic [7:0] rdata,
   // Two-wire bus.
   bls_if.host bus
);
   if (HALF_DIV < 8'd4) begin : g_div_check
      $error("HALF_DIV too small");
   end
   bls_host_state_e st_r;
   logic [7:0] div_r;
   logic ph_r;
   logic scl_r;
   logic sda_r;
   logic [7:0] sh_r;
   logic [2:0] bit_r;
   logic [2:0] byte_r;
   logic rd_r;
   logic [7:0] idx_r;
   logic [7:0] wd_r;
   logic busy_r;
   logic done_r;
   logic nack_r;
   logic [7:0] rdata_r;
   logic [1:0] dsync_r;
   wire tick = (div_r == 8'd0);
   wire din = dsync_r[1];
   // Byte count: write has 3, read has 4 (address, index, address, data).
   wire [2:0] last_byte = rd_r ? 3'd3 : 3'd2;
   wire rx_byte = rd_r && (byte_r == 3'd3);
   wire [7:0] next_tx = (byte_r == 3'd0) ? idx_r
      : (byte_r == 3'd1) ? (rd_r ? `BLS_ADDR_RD : wd_r) : 8'hff;
   assign busy = busy_r;
   assign done = done_r;
   assign nack = nack_r;
   assign rdata = rdata_r;
   assign bus.clk_o = scl_r;
   assign bus.clk_oe_n = 1'b0;
   assign bus.dat_h_o = sda_r;
   assign bus.dat_h_oe_n = 1'b0;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dsync_r <= 2'b11;
      end else begin
         dsync_r <= {dsync_r[0], bus.two_wire_data_pin};
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_r <= 8'd0;
      end else begin
         div_r <= tick ? HALF_DIV - 8'd1 : div_r - 8'd1;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= BLS_H_IDLE;
         ph_r <= 1'b0;
         scl_r <= 1'b1;
         sda_r <= 1'b1;
         sh_r <= 8'h00;
         bit_r <= 3'd0;
         byte_r <= 3'd0;
         rd_r <= 1'b0;
         idx_r <= 8'h00;
         wd_r <= 8'h00;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         nack_r <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         done_r <= 1'b0;
         if (st_r == BLS_H_IDLE) begin
            if (req) begin
               rd_r <= req_read;
               idx_r <= req_index;
               wd_r <= req_wdata;
               busy_r <= 1'b1;
               nack_r <= 1'b0;
               byte_r <= 3'd0;
               sh_r <= `BLS_ADDR_WR;
               ph_r <= 1'b0;
               st_r <= BLS_H_START;
            end
         end else if (tick) begin
            ph_r <= ~ph_r;
            unique case (st_r)
               BLS_H_START: begin
                  if (!ph_r) begin
                     sda_r <= 1'b0;
                  end else begin
                     scl_r <= 1'b0;
                     bit_r <= 3'd7;
                     st_r <= BLS_H_BIT;
                  end
               end
               BLS_H_BIT: begin
                  if (!ph_r) begin
                     sda_r <= rx_byte ? 1'b1 : sh_r[7];
                     scl_r <= 1'b0;
                  end else begin
                     scl_r <= 1'b1;
                     sh_r <= {sh_r[6:0], din};
                     if (bit_r == 3'd0) begin
                        st_r <= BLS_H_ACK;
                     end
                     bit_r <= bit_r - 3'd1;
                  end
               end
               BLS_H_ACK: begin
                  if (!ph_r) begin
                     scl_r <= 1'b0;
                     // Release for the slave acknowledge; the read byte is not acknowledged.
                     sda_r <= 1'b1;
                     if (rx_byte) begin
                        rdata_r <= sh_r;
                     end
                  end else begin
                     scl_r <= 1'b1;
                     if (!rx_byte && din) begin
                        nack_r <= 1'b1;
                        st_r <= BLS_H_STOP;
                     end else if (byte_r == last_byte) begin
                        st_r <= BLS_H_STOP;
                     end else if (rd_r && byte_r == 3'd1) begin
                        st_r <= BLS_H_RSTART;
                     end else begin
                        sh_r <= next_tx;
                        byte_r <= byte_r + 3'd1;
                        bit_r <= 3'd7;
                        st_r <= BLS_H_BIT;
                     end
                  end
               end
               BLS_H_RSTART: begin
                  if (!ph_r) begin
                     scl_r <= 1'b0;
                     sda_r <= 1'b1;
                  end else begin
                     scl_r <= 1'b1;
                     sh_r <= next_tx;
                     byte_r <= byte_r + 3'd1;
                     st_r <= BLS_H_START;
                  end
               end
               BLS_H_STOP: begin
                  if (!ph_r) begin
                     scl_r <= 1'b0;
                     sda_r <= 1'b0;
                  end else begin
                     scl_r <= 1'b1;
                     st_r <= BLS_H_DONE;
                  end
               end
               BLS_H_DONE: begin
                  sda_r <= 1'b1;
                  busy_r <= 1'b0;
                  done_r <= 1'b1;
                  st_r <= BLS_H_IDLE;
               end
               default: st_r <= BLS_H_IDLE;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ===== rtl/bls_slave.sv
// Backlight controller two-wire slave port with its byte-wide control registers.
//
// Overview of operation
// - LED driving off until host writes enable
// - Unused bus: host holds both lines low
// - Unused bus: switching fixed at 600 kHz
// - Write is address, index, then data
// - Slave drives data only for acks, read data
// - Read: address, index, restart, address, data
// - Read data equals selected register content
// - Address upper nibble must be 0101
// - Address bit 3 set; bit 0 direction
// - Address bytes are 0x58 write, 0x59 read
// - Registers eight bits; reserved bits read zero
// - Undervoltage reset stops until re-enabled
`timescale 1ns/1ps
`default_nettype none
`include "bls_defs.svh"
module bls_slave import bls_pkg::*; #(
   parameter logic [7:0] ID_VALUE = 8'h80 // Arbitrary identity value.
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Device side.
   input wire logic uv_reset,
   input wire logic [5:0] status_in,
   output logic led_enable,
   output logic fsw_600k,
   output logic bus_unused,
   output logic [7:0] brightness,
   output logic [7:0] brightness_dc,
   output logic [5:0] chan_enable,
   output logic [7:0] phase_shift,
   output logic [7:0] control,
   // Two-wire bus.
   bls_if.slave bus
);
   bls_slv_state_e st_r;
   logic [1:0] csync_r;
   logic [1:0] dsync_r;
   logic cprev_r;
   logic dprev_r;
   logic [7:0] sh_r;
   logic [3:0] cnt_r;
   logic ackph_r;
   logic drv_r;
   logic out_r;
   logic [7:0] idx_r;
   logic [1:0] nbyte_r;
   logic [7:0] brt_r;
   logic [7:0] ctrl_r;
   logic [7:0] brtdc_r;
   logic [7:0] cfg_r;
   logic [7:0] chan_r;
   logic [7:0] phase_r;
   logic uvsync0_r;
   logic uvsync1_r;
   logic unused_r;
   logic [5:0] stat_r;
   logic [10:0] low_cnt_r;
   wire scl = csync_r[1];
   wire sda = dsync_r[1];
   wire low_full = (low_cnt_r == `BLS_UNUSED_LOW);
   wire scl_rise = scl && !cprev_r;
   wire scl_fall = !scl && cprev_r;
   wire start_c = scl && cprev_r && !sda && dprev_r;
   wire stop_c = scl && cprev_r && sda && !dprev_r;
   wire [7:0] rx_byte = {sh_r[6:0], sda};
   wire byte_done = scl_rise && (cnt_r == 4'd7) && !ackph_r;
   wire addr_wr = (rx_byte[7:4] == `BLS_CLASS_NIBBLE) && rx_byte[`BLS_ADDR_BIT3]
      && (rx_byte == `BLS_ADDR_WR);
   wire addr_rd = (rx_byte == `BLS_ADDR_RD) && (nbyte_r == 2'd2);
   wire [7:0] stat_word = {2'b00, stat_r[5:4], ctrl_r[`BLS_CTL_ON_BIT], stat_r[2:0]};

   // Register read mux, reserved bits zero.
   function automatic logic [7:0] rd_mux(input logic [7:0] idx);
      unique case (idx)
         `BLS_REG_BRT: rd_mux = brt_r;
         `BLS_REG_CTRL: rd_mux = ctrl_r & `BLS_CTRL_MASK;
         `BLS_REG_STAT: rd_mux = stat_word;
         `BLS_REG_ID: rd_mux = ID_VALUE;
         `BLS_REG_BRTDC: rd_mux = brtdc_r;
         `BLS_REG_CFG: rd_mux = cfg_r & `BLS_CFG_MASK;
         `BLS_REG_CHAN: rd_mux = chan_r & `BLS_CHAN_MASK;
         `BLS_REG_PHASE: rd_mux = phase_r;
         default: rd_mux = 8'h00;
      endcase
   endfunction

   assign bus.dat_s_o = out_r;
   assign bus.dat_s_oe_n = !drv_r;

   // ===========================================================
   // Pin synchronisers.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // Reset to the pulled-up idle level so that no false edge follows reset.
         csync_r <= 2'b11;
         dsync_r <= 2'b11;
         cprev_r <= 1'b1;
         dprev_r <= 1'b1;
         uvsync0_r <= 1'b0;
         uvsync1_r <= 1'b0;
      end else begin
         csync_r <= {csync_r[0], bus.two_wire_clock_pin};
         dsync_r <= {dsync_r[0], bus.two_wire_data_pin};
         cprev_r <= csync_r[1];
         dprev_r <= dsync_r[1];
         uvsync0_r <= uv_reset;
         uvsync1_r <= uvsync0_r;
      end
   end

   // ===========================================================
   // Bus-unused detection: both lines low for longer than any clock-low phase of a transfer.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         low_cnt_r <= 11'd0;
         unused_r <= 1'b0;
         fsw_600k <= 1'b1;
         stat_r <= 6'h00;
         bus_unused <= 1'b0;
      end else begin
         low_cnt_r <= (scl || sda) ? 11'd0 : low_cnt_r + {10'd0, !low_full};
         unused_r <= low_full;
         bus_unused <= unused_r;
         fsw_600k <= unused_r || cfg_r[`BLS_CFG_FSW_BIT];
         stat_r <= status_in;
      end
   end

   // ===========================================================
   // Protocol engine.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= BLS_ST_IDLE;
         sh_r <= 8'h00;
         cnt_r <= 4'd0;
         ackph_r <= 1'b0;
         drv_r <= 1'b0;
         out_r <= 1'b1;
         idx_r <= 8'h00;
         nbyte_r <= 2'd0;
         brt_r <= `BLS_RST_BRT;
         ctrl_r <= `BLS_RST_CTRL;
         brtdc_r <= `BLS_RST_BRTDC;
         cfg_r <= `BLS_RST_CFG;
         chan_r <= `BLS_RST_CHAN;
         phase_r <= `BLS_RST_PHASE;
      end else if (uvsync1_r) begin
         ctrl_r[`BLS_CTL_ON_BIT] <= 1'b0;
         st_r <= BLS_ST_IDLE;
         drv_r <= 1'b0;
      end else if (stop_c) begin
         st_r <= BLS_ST_IDLE;
         drv_r <= 1'b0;
      end else if (start_c) begin
         st_r <= BLS_ST_ADDR;
         cnt_r <= 4'd0;
         ackph_r <= 1'b0;
         drv_r <= 1'b0;
         if (st_r != BLS_ST_DATA) begin
            nbyte_r <= 2'd0;
         end
      end else begin
         if (scl_rise && !ackph_r) begin
            sh_r <= rx_byte;
            cnt_r <= cnt_r + 4'd1;
         end
         if (byte_done) begin
            ackph_r <= 1'b1;
            cnt_r <= 4'd0;
            unique case (st_r)
               BLS_ST_ADDR: begin
                  if (addr_wr && nbyte_r == 2'd0) begin
                     st_r <= BLS_ST_CMD;
                     nbyte_r <= 2'd1;
                  end else if (addr_rd) begin
                     st_r <= BLS_ST_READ;
                     sh_r <= rd_mux(idx_r);
                  end else begin
                     st_r <= BLS_ST_SKIP;
                  end
               end
               BLS_ST_CMD: begin
                  idx_r <= rx_byte;
                  nbyte_r <= 2'd2;
                  st_r <= BLS_ST_DATA;
               end
               BLS_ST_DATA: begin
                  unique case (idx_r)
                     `BLS_REG_BRT: brt_r <= rx_byte;
                     `BLS_REG_CTRL: ctrl_r <= rx_byte & `BLS_CTRL_MASK;
                     `BLS_REG_BRTDC: brtdc_r <= rx_byte;
                     `BLS_REG_CFG: cfg_r <= rx_byte & `BLS_CFG_MASK;
                     `BLS_REG_CHAN: chan_r <= rx_byte & `BLS_CHAN_MASK;
                     `BLS_REG_PHASE: phase_r <= rx_byte;
                     default: ;
                  endcase
                  // Stay here through the acknowledge, then ignore any further byte.
                  nbyte_r <= 2'd3;
               end
               default: ;
            endcase
         end
         if (scl_fall) begin
            // Acknowledge first; a read then drives its byte in the next eight slots.
            if (ackph_r && cnt_r == 4'd0 && st_r != BLS_ST_SKIP) begin
               drv_r <= 1'b1;
               out_r <= 1'b0;
               cnt_r <= (st_r == BLS_ST_READ) ? 4'd7 : 4'd8;
            end else if (cnt_r >= 4'd7 && cnt_r < 4'd15 && st_r == BLS_ST_READ) begin
               out_r <= sh_r[7];
               cnt_r <= cnt_r + 4'd1;
            end else begin
               drv_r <= 1'b0;
               if (cnt_r == 4'd8 || cnt_r == 4'd15) begin
                  cnt_r <= 4'd0;
                  ackph_r <= 1'b0;
               end
               if (st_r == BLS_ST_SKIP && cnt_r == 4'd0 && ackph_r) begin
                  ackph_r <= 1'b0;
               end
               if (cnt_r == 4'd15 || (cnt_r == 4'd8 && nbyte_r == 2'd3)) begin
                  st_r <= BLS_ST_SKIP;
               end
            end
         end
         if (scl_rise && st_r == BLS_ST_READ && cnt_r >= 4'd8) begin
            sh_r <= {sh_r[6:0], 1'b0};
         end
      end
   end

   // ===========================================================
   // Register outputs.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         led_enable <= 1'b0;
         brightness <= `BLS_RST_BRT;
         brightness_dc <= `BLS_RST_BRTDC;
         chan_enable <= 6'h3f;
         phase_shift <= `BLS_RST_PHASE;
         control <= `BLS_RST_CTRL;
      end else begin
         led_enable <= ctrl_r[`BLS_CTL_ON_BIT] && !uvsync1_r;
         brightness <= brt_r;
         brightness_dc <= brtdc_r;
         chan_enable <= chan_r[5:0];
         phase_shift <= phase_r;
         control <= ctrl_r;
      end
   end
endmodule
`default_nettype wire

// ===== verif/bls_port_sva.sv
// Concurrent checks on the two-wire bus joining the host and slave ends.
`timescale 1ns/1ps
`default_nettype none
module bls_port_sva (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Resolved bus pins.
   input wire logic two_wire_clock_pin,
   input wire logic two_wire_data_pin,
   // Data line drivers.
   input wire logic dat_h_o,
   input wire logic dat_h_oe_n,
   input wire logic dat_s_o,
   input wire logic dat_s_oe_n
);
   // ==========================================================
   // Frame tracking: counts clock rises since the last start.
   logic clk_q_r;
   logic dat_q_r;
   logic [5:0] cnt_r;
   logic [5:0] cnt_nxt;
   logic [7:0] sh_r;
   logic [7:0] addr_r;
   wire rise = two_wire_clock_pin && !clk_q_r;
   wire start = clk_q_r && two_wire_clock_pin && dat_q_r && !two_wire_data_pin;
   wire host_low = !dat_h_oe_n && !dat_h_o;
   assign cnt_nxt = start ? 6'h00 : (rise && cnt_r != 6'h3f) ? cnt_r + 6'h01 : cnt_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clk_q_r <= 1'b1;
         dat_q_r <= 1'b1;
         cnt_r <= 6'h00;
         sh_r <= 8'h00;
         addr_r <= 8'h00;
      end else begin
         clk_q_r <= two_wire_clock_pin;
         dat_q_r <= two_wire_data_pin;
         cnt_r <= cnt_nxt;
         sh_r <= rise ? {sh_r[6:0], two_wire_data_pin} : sh_r;
         addr_r <= (rise && cnt_r == 6'h08) ? sh_r : addr_r;
      end
   end
   // ==========================================================
   // Assertions.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   a_slave_low_clk: assert property ($changed(dat_s_oe_n) |-> !two_wire_clock_pin)
      else $error("slave data enable moved while clock high");
   a_addr_quiet: assert property (cnt_r < 6'h08 |-> dat_s_oe_n)
      else $error("slave drove data during address bits");
   a_wr_addr_ack: assert property (rise && cnt_r == 6'h08 && sh_r == 8'h58 |-> !two_wire_data_pin)
      else $error("write address not acknowledged");
   a_rd_addr_ack: assert property (rise && cnt_r == 6'h08 && sh_r == 8'h59 |-> !two_wire_data_pin)
      else $error("read address not acknowledged");
   a_index_ack: assert property (rise && cnt_r == 6'h11 && addr_r == 8'h58 |-> !two_wire_data_pin)
      else $error("index byte not acknowledged");
   a_data_ack: assert property (rise && cnt_r == 6'h1a && addr_r == 8'h58 |-> !two_wire_data_pin)
      else $error("data byte not acknowledged");
   a_rd_release: assert property (rise && cnt_r == 6'h11 && addr_r == 8'h59 |-> dat_s_oe_n)
      else $error("slave held data line in final read slot");
   a_host_ack_free: assert property (rise && (cnt_r == 6'h08 || cnt_r == 6'h1a) |-> !host_low)
      else $error("host pulled data low in an acknowledge slot");
   a_host_rd_free: assert property (rise && addr_r == 8'h59 && cnt_r > 6'h08 && cnt_r < 6'h11
      |-> !host_low)
      else $error("host pulled data low during read data");
   a_ack_hold: assert property ($fell(dat_s_oe_n) |-> !dat_s_oe_n [*4])
      else $error("slave released data line too early");
endmodule
`default_nettype wire

// ===== verif/backlight_smbus_slave_port_test.sv
// Self-checking bench for the backlight two-wire host and slave ends.
`timescale 1ns/1ps
`default_nettype none
`include "bls_defs.svh"
module backlight_smbus_slave_port_test;
   localparam logic [7:0] ID_V = 8'h80; // Arbitrary identity value.
   logic clk, rst, req, req_read, uv_reset, busy, done, nack, ack;
   logic [7:0] req_index, req_wdata, rdata, brightness, brightness_dc, phase_shift, control;
   logic [5:0] status_in, chan_enable;
   logic led_enable, fsw_600k, bus_unused, fsw_b, unused_b;
   logic [7:0] m [0:15];
   logic [7:0] idx_q [$] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h05};
   int err_total, checks, seed;
   bls_if i_bus();
   bls_if i_bus_b();
   bls_host #(.HALF_DIV(8'd8)) i_bls_host (.clk(clk), .rst(rst), .req(req), .req_read(req_read),
      .req_index(req_index), .req_wdata(req_wdata), .busy(busy), .done(done), .nack(nack),
      .rdata(rdata), .bus(i_bus.host));
   bls_slave #(.ID_VALUE(ID_V)) i_bls_slave (.clk(clk), .rst(rst), .uv_reset(uv_reset),
      .status_in(status_in), .led_enable(led_enable), .fsw_600k(fsw_600k),
      .bus_unused(bus_unused), .brightness(brightness), .brightness_dc(brightness_dc),
      .chan_enable(chan_enable), .phase_shift(phase_shift), .control(control),
      .bus(i_bus.slave));
   bls_slave #(.ID_VALUE(ID_V)) i_bls_slave_b (.clk(clk), .rst(rst), .uv_reset(1'b0),
      .status_in(6'h00), .led_enable(), .fsw_600k(fsw_b), .bus_unused(unused_b), .brightness(),
      .brightness_dc(), .chan_enable(), .phase_shift(), .control(), .bus(i_bus_b.slave));
   bls_port_sva i_bls_port_sva (.clk(clk), .rst(rst),
      .two_wire_clock_pin(i_bus.two_wire_clock_pin), .two_wire_data_pin(i_bus.two_wire_data_pin),
      .dat_h_o(i_bus.dat_h_o), .dat_h_oe_n(i_bus.dat_h_oe_n), .dat_s_o(i_bus.dat_s_o),
      .dat_s_oe_n(i_bus.dat_s_oe_n));
   // ==========================================================
   // Comparison, verdict and register model.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t ns: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      if (err_total == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   function automatic logic [7:0] wmask(input logic [7:0] idx);
      case (idx)
         8'h00, 8'h07, 8'h0a: wmask = 8'hff;
         8'h01: wmask = 8'h07;
         8'h08: wmask = 8'h7f;
         8'h09: wmask = 8'h3f;
         default: wmask = 8'h00;
      endcase
   endfunction
   function automatic logic [7:0] expect_rd(input logic [7:0] idx);
      if (idx == 8'h02) expect_rd = {2'b00, status_in[5:4], m[1][0], status_in[2:0]};
      else if (idx == 8'h03) expect_rd = ID_V;
      else expect_rd = m[idx[3:0]];
   endfunction
   // ==========================================================
   // Host transfers on the main bus.
   task automatic xfer(input logic rd, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(negedge clk);
      req = 1'b1;
      req_read = rd;
      req_index = idx;
      req_wdata = wd;
      @(negedge clk);
      req = 1'b0;
      while (done !== 1'b1 && n < 4000) begin
         @(negedge clk);
         n++;
      end
      check({6'h00, busy, done}, 8'h01);
      check({7'h00, nack}, 8'h00);
      if (!rd) m[idx[3:0]] = wd & wmask(idx);
      if (rd) check(rdata, expect_rd(idx));
   endtask
   task automatic check_outs();
      check(brightness, m[0]);
      check(control, m[1]);
      check(brightness_dc, m[7]);
      check({2'b00, chan_enable}, m[9]);
      check(phase_shift, m[10]);
      check({6'h00, bus_unused, led_enable}, {7'h00, m[1][0]});
      check({7'h00, fsw_600k}, {7'h00, m[8][2]});
   endtask
   // ==========================================================
   // Bench-driven second bus with a 200 ns link clock.
   task automatic half();
      repeat (2) @(negedge clk);
   endtask
   task automatic bb_bit(input logic b);
      i_bus_b.clk_o = 1'b0;
      half();
      i_bus_b.dat_h_o = b;
      half();
      i_bus_b.clk_o = 1'b1;
      half();
      ack = i_bus_b.two_wire_data_pin;
      half();
   endtask
   task automatic bb_frame(input logic [7:0] a, input logic want);
      logic [23:0] w;
      w = {a, `BLS_REG_CFG, 8'h00};
      i_bus_b.dat_h_o = 1'b0;
      half();
      for (int i = 23; i >= 0; i--) begin
         bb_bit(w[i]);
         if (i % 8 == 0) begin
            bb_bit(1'b1);
            check({7'h00, ack}, {7'h00, !want});
         end
      end
      bb_bit(1'b0);
      i_bus_b.dat_h_o = 1'b1;
      half();
   endtask
   // ==========================================================
   // Clock, watchdog and main sequence.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (90000) @(posedge clk);
      err_total++;
      finish_test();
   end
   initial begin
      seed = 67;
      err_total = 0;
      checks = 0;
      req = 1'b0;
      req_read = 1'b0;
      req_index = 8'h00;
      req_wdata = 8'h00;
      uv_reset = 1'b0;
      status_in = 6'h00;
      i_bus_b.clk_oe_n = 1'b0;
      i_bus_b.dat_h_oe_n = 1'b0;
      i_bus_b.clk_o = 1'b1;
      i_bus_b.dat_h_o = 1'b1;
      for (int i = 0; i < 16; i++) m[i] = 8'h00;
      m[0] = 8'hff;
      m[7] = 8'hff;
      m[8] = 8'h1f;
      m[9] = 8'h3f;
      rst = 1'b1;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      check_outs();
      foreach (idx_q[k]) xfer(1'b1, idx_q[k], 8'h00);
      for (int r = 0; r < 2; r++) begin
         foreach (idx_q[k]) begin
            status_in = 6'($random(seed));
            xfer(1'b0, idx_q[k], 8'($random(seed)));
            xfer(1'b1, idx_q[k], 8'h00);
            check_outs();
         end
      end
      xfer(1'b0, 8'h01, 8'h01);
      check_outs();
      uv_reset = 1'b1;
      repeat (4) @(negedge clk);
      uv_reset = 1'b0;
      repeat (8) @(negedge clk);
      m[1][0] = 1'b0;
      check_outs();
      xfer(1'b1, 8'h01, 8'h00);
      xfer(1'b0, 8'h01, 8'h01);
      check_outs();
      bb_frame(8'h50, 1'b0);
      bb_frame(8'hd8, 1'b0);
      bb_frame(8'h59, 1'b0);
      bb_frame(8'h58, 1'b1);
      check({6'h00, unused_b, fsw_b}, 8'h00);
      i_bus_b.clk_o = 1'b0;
      i_bus_b.dat_h_o = 1'b0;
      repeat (`BLS_UNUSED_LOW / 2) @(negedge clk);
      check({6'h00, unused_b, fsw_b}, 8'h00);
      repeat (`BLS_UNUSED_LOW) @(negedge clk);
      check({6'h00, unused_b, fsw_b}, 8'h03);
      finish_test();
   end
endmodule
`default_nettype wire
